/* core/fioh_pkg.sv */
// constants, field layouts and mode codes of the fast i/o helper
`default_nettype none
//
// Operation
// - 24 match flags, each high while the count equals its own 32-bit preset: the second count in counter mode, the first in up/down mode.
// - the fast counter takes 7 kHz pulses, checks 24 presets and interrupts on a match.
// - in plain counter mode the count only goes up, and a reset input returns it to zero.
// - quadrature inputs up to 7 kHz move the count up or down by direction, with a reset input.
// - pulse catch latches a pulse as short as 100 us on one input until software clears its status bit.
// - every fast input gets an on and off delay filter settable up to 99 ms.
// - with no other function chosen the four fast inputs are filtered inputs.
// - a single-axis pulse train up to 10 kHz with trapezoid, registration and velocity profiles.
// - only one fast function runs at a time, never pulse output beside an input function.
// - the unit owns only four fast inputs and two fast outputs.
// - in the default mode outputs pass straight from cpu to pins and inputs reach the cpu through their filters.
// - any other mode replaces the plain behaviour of the dedicated points.
// - the unit samples and captures continuously, independent of the cpu scan.
// - the fast count runs from zero up to at most 99999999.
// - a 16-bit bcd mode word holds the mode number in its low eight bits.
// - after reset the mode is filtered input with a 10 ms delay and plain outputs.
package fioh_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_FILTER = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_PCOUNT = 8'h10;
    localparam logic [7:0] OFS_COUNT_A = 8'h14;
    localparam logic [7:0] OFS_COUNT_B = 8'h18;
    localparam logic [7:0] OFS_MATCH = 8'h1C;
    localparam logic [7:0] OFS_INT_STAT = 8'h20;
    localparam logic [7:0] OFS_INT_MASK = 8'h24;
    localparam logic [7:0] OFS_INPUTS = 8'h28;
    localparam logic [7:0] OFS_PRESET = 8'h80;
    // mode numbers, bcd
    localparam logic [7:0] MODE_COUNTER = 8'h10;
    localparam logic [7:0] MODE_UPDOWN = 8'h20;
    localparam logic [7:0] MODE_PULSE = 8'h30;
    localparam logic [7:0] MODE_INTR = 8'h40;
    localparam logic [7:0] MODE_CATCH = 8'h50;
    localparam logic [7:0] MODE_FILTER = 8'h60;
    // control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_DIR = 2;
    localparam int CTRL_PROF = 4;
    localparam logic [1:0] PROF_TRAP = 2'h0;
    localparam logic [1:0] PROF_REG = 2'h1;
    localparam logic [1:0] PROF_VEL = 2'h2;
    // interrupt status bits
    localparam int INT_MATCH = 0;
    localparam int INT_DONE = 1;
    localparam int INT_EDGE = 2;
    localparam int INT_CATCH = 3;
    localparam int INT_W = 4;
    // reset values and limits
    localparam logic [15:0] RST_MODE = 16'h0060;
    localparam logic [7:0] RST_FILTER_MS = 8'h0A;
    localparam logic [7:0] MAX_FILTER_MS = 8'h63;
    localparam logic [31:0] COUNT_MAX = 32'h05F5E0FF;
    localparam int NUM_PRESETS = 24;
    localparam int PRESET_AW = 5;
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int FILTER_TICK_MS = 1;
    localparam int FILTER_TICK_CYCLES = CLK_HZ / 1000 * FILTER_TICK_MS;
    localparam int PULSE_MAX_HZ = 10000;
    localparam int PULSE_MIN_HALF =
        (CLK_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ);
    localparam logic [15:0] RST_HALF = 16'(PULSE_MIN_HALF);
    // pulse generator states
    typedef enum logic [1:0] {P_IDLE, P_FREE, P_COUNT} fioh_pulse_t;
endpackage : fioh_pkg
`default_nettype wire

/* core/fioh_mem_if.sv */
// preset memory port between the top and the preset store
`default_nettype none
interface fioh_mem_if;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [4:0] rd_addr;
    logic [31:0] rd_data;
    modport host (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : fioh_mem_if
`default_nettype wire

/* core/fioh_filter.sv */
// on/off delay filter for one fast input
`default_nettype none
module fioh_filter
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // timing
    input wire logic tick,
    input wire logic [7:0] delay,
    // signal
    input wire logic raw,
    output logic level
);
    logic level_reg, level_next;
    logic [7:0] cnt_reg, cnt_next;

    assign level = level_reg;

    // one delay for both edges
    always_comb
    begin
        level_next = level_reg;
        cnt_next = cnt_reg;
        if (raw == level_reg)
        begin
            cnt_next = 8'h00;
        end
        else if (cnt_reg >= delay)
        begin
            level_next = raw;
            cnt_next = 8'h00;
        end
        else if (tick)
        begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end
        else if (ce)
        begin
            level_reg <= level_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule : fioh_filter
`default_nettype wire

/* core/fioh_preset_mem.sv */
// preset store with registered read
`default_nettype none
module fioh_preset_mem
#(
    parameter int DEPTH = 24
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // port
    fioh_mem_if.store mp
);
    logic [31:0] mem [DEPTH];
    logic [31:0] rd_reg;

    if (DEPTH < 1 || DEPTH > 32)
    begin : g_chk
        $error("preset depth out of range");
    end

    assign mp.rd_data = rd_reg;

    always_ff @(posedge clk)
    begin
        if (ce && mp.wr_en)
        begin
            mem[mp.wr_addr] <= mp.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_reg <= 32'h0000_0000;
        end
        else if (ce)
        begin
            rd_reg <= mem[mp.rd_addr];
        end
    end
endmodule : fioh_preset_mem
`default_nettype wire

/* core/fioh_top.sv */
// fast i/o helper: counters, pulse catch, filters, pulse output
//
// Our own choices: register access over APB and the placing of the registers.
`default_nettype none
module fioh_top
#(
    parameter int FILTER_TICK_CYC = fioh_pkg::FILTER_TICK_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // field pins
    input wire logic fast_input_first,
    input wire logic fast_input_second,
    input wire logic fast_input_third,
    input wire logic fast_input_fourth,
    output logic fast_output_pulse,
    output logic fast_output_direction,
    // cpu side
    output logic [3:0] cpu_in_level,
    input wire logic [1:0] cpu_out_level,
    output logic [fioh_pkg::NUM_PRESETS-1:0] second_counter_match_flags,
    output logic irq
);
    import fioh_pkg::*;

    if (FILTER_TICK_CYC < 1)
    begin : g_chk
        $error("filter tick must be at least one cycle");
    end

    //////////////////////////////////////////////////////////////////////
    // decode
    function automatic logic addr_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_INPUTS ||
            (a >= OFS_PRESET && a[6:2] < 5'(NUM_PRESETS)));
    endfunction : addr_hit

    function automatic logic [3:0] dedicated(input logic [7:0] m);
        unique case (m)
            MODE_COUNTER: return 4'hF;
            MODE_UPDOWN: return 4'h7;
            MODE_INTR, MODE_CATCH: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction : dedicated

    //////////////////////////////////////////////////////////////////////
    // pin synchronisers and edges
    logic [3:0] pin_s1, pin_s2, pin_prev;
    logic [3:0] rise;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_prev <= 4'h0;
        end
        else if (ce)
        begin
            pin_s1 <= {fast_input_fourth, fast_input_third,
            fast_input_second, fast_input_first};
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    assign rise = pin_s2 & ~pin_prev;

    //////////////////////////////////////////////////////////////////////
    // filters
    logic [31:0] tick_reg, tick_next;
    logic tick;
    logic [31:0] fdelay_reg, fdelay_next;
    logic [3:0] filt;

    assign tick = (tick_reg == 32'(FILTER_TICK_CYC - 1));

    always_comb
    begin
        tick_next = tick ? 32'h0 : tick_reg + 32'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_reg <= 32'h0;
        end
        else if (ce)
        begin
            tick_reg <= tick_next;
        end
    end

    for (genvar i = 0; i < 4; i++)
    begin : g_filt
        logic [7:0] dly;
        assign dly = (fdelay_reg[8*i +: 8] > MAX_FILTER_MS) ?
            MAX_FILTER_MS : fdelay_reg[8*i +: 8];
        fioh_filter u_filt (
            .clk(pclk),
            .rst_n(presetn),
            .ce(ce),
            .tick(tick),
            .delay(dly),
            .raw(pin_s2[i]),
            .level(filt[i])
        );
    end

    //////////////////////////////////////////////////////////////////////
    // preset store
    fioh_mem_if mem_bus ();
    logic [4:0] scan_reg, scan_next, scan_prev_reg;
    logic wr_acc, rd_setup;

    assign wr_acc = ce && psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign mem_bus.wr_en = wr_acc && addr_hit(paddr) && paddr >= OFS_PRESET;
    assign mem_bus.wr_addr = paddr[6:2];
    assign mem_bus.wr_data = pwdata;
    assign mem_bus.rd_addr = scan_reg;

    fioh_preset_mem #(.DEPTH(NUM_PRESETS)) u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .mp(mem_bus.store)
    );

    //////////////////////////////////////////////////////////////////////
    // main state
    logic [15:0] mode_reg, mode_next;
    logic [1:0] prof_reg, prof_next;
    logic dir_reg, dir_next;
    logic [15:0] half_reg, half_next, half_eff;
    logic [31:0] pcount_reg, pcount_next;
    logic [31:0] count_a_reg, count_a_next, count_b_reg, count_b_next;
    logic [31:0] cmp_count;
    logic [23:0] match_reg, match_next;
    logic [INT_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
    fioh_pulse_t pst_reg, pst_next;
    logic [15:0] phase_reg, phase_next;
    logic [31:0] left_reg, left_next;
    logic pulse_reg, pulse_next;
    logic [1:0] out_reg, out_next;
    logic [3:0] cpu_reg, cpu_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [7:0] mode;
    logic counting, start, stop;

    assign mode = mode_reg[7:0];
    assign counting = (mode == MODE_COUNTER) || (mode == MODE_UPDOWN);
    assign cmp_count = (mode == MODE_UPDOWN) ? count_a_reg : count_b_reg;
    assign half_eff = (half_reg < RST_HALF) ? RST_HALF : half_reg;
    assign start = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_START];
    assign stop = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_STOP];

    always_comb
    begin
        mode_next = mode_reg;
        fdelay_next = fdelay_reg;
        prof_next = prof_reg;
        dir_next = dir_reg;
        half_next = half_reg;
        pcount_next = pcount_reg;
        mask_next = mask_reg;
        count_a_next = count_a_reg;
        count_b_next = count_b_reg;
        match_next = match_reg;
        pst_next = pst_reg;
        phase_next = phase_reg;
        left_next = left_reg;
        pulse_next = pulse_reg;
        ev = '0;
        // software writes
        if (wr_acc)
        begin
            unique case (paddr)
                OFS_MODE: mode_next = pwdata[15:0];
                OFS_FILTER: fdelay_next = pwdata;
                OFS_CTRL:
                begin
                    dir_next = pwdata[CTRL_DIR];
                    prof_next = pwdata[CTRL_PROF +: 2];
                end
                OFS_PERIOD: half_next = pwdata[15:0];
                OFS_PCOUNT: pcount_next = pwdata;
                OFS_INT_MASK: mask_next = pwdata[INT_W-1:0];
                default: ;
            endcase
        end
        // counters, free of the cpu scan
        if (mode == MODE_COUNTER)
        begin
            if (pin_s2[2])
            begin
                count_a_next = 32'h0;
            end
            else if (rise[0] && count_a_reg < COUNT_MAX)
            begin
                count_a_next = count_a_reg + 32'h1;
            end
            if (pin_s2[3])
            begin
                count_b_next = 32'h0;
            end
            else if (rise[1] && count_b_reg < COUNT_MAX)
            begin
                count_b_next = count_b_reg + 32'h1;
            end
        end
        else if (mode == MODE_UPDOWN)
        begin
            if (pin_s2[2])
            begin
                count_a_next = 32'h0;
            end
            else if (rise[0] && !pin_s2[1] && count_a_reg < COUNT_MAX)
            begin
                count_a_next = count_a_reg + 32'h1;
            end
            else if (rise[0] && pin_s2[1] && count_a_reg != 32'h0)
            begin
                count_a_next = count_a_reg - 32'h1;
            end
        end
        // preset compare, one preset per cycle
        if (!counting)
        begin
            match_next = 24'h0;
        end
        else
        begin
            match_next[scan_prev_reg] =
                (mem_bus.rd_data == cmp_count);
        end
        ev[INT_MATCH] = |(match_next & ~match_reg);
        ev[INT_EDGE] = (mode == MODE_INTR) && rise[0];
        ev[INT_CATCH] = (mode == MODE_CATCH) && rise[0];
        // pulse generator
        unique case (pst_reg)
            P_IDLE:
            begin
                if (start && mode == MODE_PULSE)
                begin
                    left_next = pcount_reg;
                    phase_next = half_eff;
                    pulse_next = 1'b0;
                    pst_next = (prof_reg == PROF_TRAP) ? P_COUNT : P_FREE;
                end
            end
            P_FREE:
            begin
                if (prof_reg == PROF_REG && rise[0])
                begin
                    pst_next = P_COUNT;
                end
            end
            P_COUNT:
            begin
                if (left_reg == 32'h0 && !pulse_reg)
                begin
                    pst_next = P_IDLE;
                    ev[INT_DONE] = 1'b1;
                end
            end
        endcase
        if (pst_reg != P_IDLE && pst_next != P_IDLE)
        begin
            if (phase_reg <= 16'h1)
            begin
                phase_next = half_eff;
                pulse_next = !pulse_reg;
                if (pulse_reg && pst_reg == P_COUNT)
                begin
                    left_next = left_reg - 32'h1;
                end
            end
            else
            begin
                phase_next = phase_reg - 16'h1;
            end
        end
        if (stop || mode != MODE_PULSE)
        begin
            pst_next = P_IDLE;
            pulse_next = 1'b0;
        end
    end

    // status: set wins over clear
    always_comb
    begin
        stat_next = stat_reg;
        if (wr_acc && paddr == OFS_INT_STAT)
        begin
            stat_next = stat_reg & ~pwdata[INT_W-1:0];
        end
        stat_next = stat_next | ev;
        scan_next = (scan_reg == 5'(NUM_PRESETS - 1)) ?
            5'h0 : scan_reg + 5'h1;
    end

    // pin and cpu views
    always_comb
    begin
        out_next = cpu_out_level;
        if (mode == MODE_PULSE)
        begin
            out_next = {dir_reg, pulse_reg};
        end
        cpu_next = filt & ~dedicated(mode);
        if (mode == MODE_CATCH)
        begin
            cpu_next[0] = pin_s2[0] | stat_reg[INT_CATCH];
        end
        prdata_next = prdata_reg;
        if (rd_setup && !pwrite)
        begin
            unique case (paddr)
                OFS_MODE: prdata_next = {16'h0, mode_reg};
                OFS_FILTER: prdata_next = fdelay_reg;
                OFS_CTRL: prdata_next = {26'h0, prof_reg, 1'b0, dir_reg,
                    pst_reg != P_IDLE, 1'b0};
                OFS_PERIOD: prdata_next = {16'h0, half_reg};
                OFS_PCOUNT: prdata_next = pcount_reg;
                OFS_COUNT_A: prdata_next = count_a_reg;
                OFS_COUNT_B: prdata_next = count_b_reg;
                OFS_MATCH: prdata_next = {8'h0, match_reg};
                OFS_INT_STAT: prdata_next = {28'h0, stat_reg};
                OFS_INT_MASK: prdata_next = {28'h0, mask_reg};
                OFS_INPUTS: prdata_next = {28'h0, filt};
                default: prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= RST_MODE;
            fdelay_reg <= {4{RST_FILTER_MS}};
            prof_reg <= PROF_TRAP;
            dir_reg <= 1'b0;
            half_reg <= RST_HALF;
            pcount_reg <= 32'h0;
            mask_reg <= '0;
            stat_reg <= '0;
            count_a_reg <= 32'h0;
            count_b_reg <= 32'h0;
            match_reg <= 24'h0;
            pst_reg <= P_IDLE;
            phase_reg <= 16'h0;
            left_reg <= 32'h0;
            pulse_reg <= 1'b0;
            out_reg <= 2'h0;
            cpu_reg <= 4'h0;
            prdata_reg <= 32'h0;
            scan_reg <= 5'h0;
            scan_prev_reg <= 5'h0;
        end
        else if (ce)
        begin
            mode_reg <= mode_next;
            fdelay_reg <= fdelay_next;
            prof_reg <= prof_next;
            dir_reg <= dir_next;
            half_reg <= half_next;
            pcount_reg <= pcount_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            count_a_reg <= count_a_next;
            count_b_reg <= count_b_next;
            match_reg <= match_next;
            pst_reg <= pst_next;
            phase_reg <= phase_next;
            left_reg <= left_next;
            pulse_reg <= pulse_next;
            out_reg <= out_next;
            cpu_reg <= cpu_next;
            prdata_reg <= prdata_next;
            scan_reg <= scan_next;
            scan_prev_reg <= scan_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign fast_output_pulse = out_reg[0];
    assign fast_output_direction = out_reg[1];
    assign cpu_in_level = cpu_reg;
    assign second_counter_match_flags = match_reg;
    assign irq = |(stat_reg & mask_reg);
endmodule : fioh_top
`default_nettype wire

/* test/fioh_field_model.sv */
// field side: sensors and encoder on the fast inputs
`default_nettype none
module fioh_field_model
(
    // clock
    input wire logic pclk,
    // pins
    output logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 4'h0;
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n)
        begin
            @(posedge pclk);
            pin[ch] <= 1'b1;
            repeat (w) @(posedge pclk);
            pin[ch] <= 1'b0;
            repeat (w) @(posedge pclk);
        end
    endtask : pulse
    task automatic level(input int ch, input logic v);
        @(posedge pclk);
        pin[ch] <= v;
    endtask : level
endmodule : fioh_field_model
`default_nettype wire

/* test/fioh_top_monitor.sv */
// port checker of the fast i/o helper
`default_nettype none
module fioh_top_monitor
(
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and cpu
    input wire logic fast_output_pulse,
    input wire logic fast_output_direction,
    input wire logic [3:0] cpu_in_level,
    input wire logic [1:0] cpu_out_level,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import fioh_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] mode_q;
    logic pass_q;
    wire logic acc = psel && penable && ce;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= RST_MODE;
            pass_q <= 1'b0;
        end
        else
        begin
            pass_q <= ce && mode_q[7:0] != MODE_PULSE;
            if (acc && pwrite && paddr == OFS_MODE)
                mode_q <= pwdata[15:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_acc;
        pslverr |-> psel && penable;
    endproperty
    a_err_acc: assert property (p_err_acc) else $error("stray error");
    property p_unmapped;
        acc && paddr == 8'h2C |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_mode_rd;
        acc && !pwrite && paddr == OFS_MODE |-> prdata[15:0] == mode_q;
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode word");
    property p_out_pass;
        pass_q |-> fast_output_pulse == $past(cpu_out_level[0]);
    endproperty
    a_out_pass: assert property (p_out_pass) else $error("out0");
    property p_dir_pass;
        pass_q |-> fast_output_direction == $past(cpu_out_level[1]);
    endproperty
    a_dir_pass: assert property (p_dir_pass) else $error("out1");
    property p_dedic;
        $past(mode_q[7:0], 2) == MODE_COUNTER
            && $past(mode_q[7:0]) == MODE_COUNTER |-> cpu_in_level == 4'h0;
    endproperty
    a_dedic: assert property (p_dedic) else $error("dedicated in");
    property p_irq_fall;
        $fell(irq) |-> $past(acc && pwrite
            && (paddr == OFS_INT_STAT || paddr == OFS_INT_MASK));
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
    c_err: cover property (acc && pslverr);
    c_irq: cover property ($rose(irq));
    c_pulse: cover property ($rose(fast_output_pulse));
endmodule : fioh_top_monitor
bind fioh_top fioh_top_monitor u_mon (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fast_output_pulse, .fast_output_direction, .cpu_in_level,
    .cpu_out_level, .irq);
`default_nettype wire

/* test/tb_fioh_top.sv */
// self-checking bench of the fast i/o helper
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH t=%0t got %h exp %h", $time, \
    (g), (e)); end end
module tb_fioh_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fioh_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, fout, fdir, er;
    logic [1:0] cpu_out = 2'h0;
    logic [3:0] cpu_in, pin;
    logic [23:0] flags;
    int failures = 0, samples_checked = 0, pulses = 0;
    fioh_top #(.FILTER_TICK_CYC(4)) dut (.pclk, .presetn, .ce(1'b1),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fast_input_first(pin[0]), .fast_input_second(pin[1]),
        .fast_input_third(pin[2]), .fast_input_fourth(pin[3]),
        .fast_output_pulse(fout), .fast_output_direction(fdir),
        .cpu_in_level(cpu_in), .cpu_out_level(cpu_out),
        .second_counter_match_flags(flags), .irq);
    fioh_field_model field (.pclk, .pin);
    initial forever #25 pclk = ~pclk;
    always @(posedge fout) pulses++;
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rdc
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_MODE, {16'h0, RST_MODE});
        rdc(OFS_FILTER, {4{RST_FILTER_MS}});
        rdc(8'h2C, 32'h0);
        `CHK(er, 1'b1)
        $display("end reset");
        cpu_out <= 2'h2;
        field.level(2, 1'b1);
        wt(80);
        `CHK({fdir, fout}, 2'h2)
        `CHK(cpu_in, 4'h4)
        field.pulse(1, 1, 10);
        wt(80);
        `CHK(cpu_in, 4'h4)
        rdc(OFS_INPUTS, 32'h4);
        field.level(2, 1'b0);
        $display("end default");
        for (int i = 0; i < 24; i++)
            wr(OFS_PRESET + 8'(4 * i), i ? 32'(28 - i) : 32'h3);
        wr(OFS_MODE, 32'(MODE_COUNTER));
        wr(OFS_INT_MASK, 32'h1);
        wr(OFS_INT_STAT, 32'hF);
        field.pulse(1, 3, 5);
        wt(40);
        rdc(OFS_COUNT_B, 32'h3);
        `CHK(flags[0], 1'b1)
        `CHK(irq, 1'b1)
        wr(OFS_INT_STAT, 32'h1);
        wt(2);
        `CHK(irq, 1'b0)
        field.pulse(1, 2, 5);
        wt(40);
        `CHK(flags, 24'h800000)
        field.level(3, 1'b1);
        wt(10);
        rdc(OFS_COUNT_B, 32'h0);
        field.level(3, 1'b0);
        $display("end counter");
        wr(OFS_MODE, MODE_UPDOWN);
        field.pulse(2, 1, 5);
        field.pulse(0, 4, 5);
        wt(10);
        rdc(OFS_COUNT_A, 32'h4);
        field.level(1, 1'b1);
        wt(4);
        field.pulse(0, 1, 5);
        wt(10);
        rdc(OFS_COUNT_A, 32'h3);
        field.level(1, 1'b0);
        $display("end updown");
        wr(OFS_MODE, MODE_PULSE);
        wr(OFS_PERIOD, 32'd1000);
        wr(OFS_PCOUNT, 32'h2);
        wr(OFS_INT_MASK, 32'h2);
        for (int p = 0; p < 3; p++)
        begin
            wr(OFS_INT_STAT, 32'hF);
            pulses = 0;
            wr(OFS_CTRL, 32'h5 | (32'(p) << CTRL_PROF));
            if (p == PROF_REG)
                field.pulse(0, 1, 5);
            if (p == PROF_VEL)
            begin
                wt(3000);
                `CHK(fdir, 1'b1)
                rdc(OFS_CTRL, 32'h26);
                wr(OFS_CTRL, 32'h2);
                rdc(OFS_CTRL, 32'h0);
            end
            else
            begin
                for (int i = 0; i < 6000 && irq !== 1'b1; i++)
                    @(posedge pclk);
                `CHK(irq, 1'b1)
                `CHK(pulses, 2)
            end
        end
        rdc(OFS_COUNT_A, 32'h3);
        $display("end pulse");
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_MODE, k ? MODE_CATCH : MODE_INTR);
            wr(OFS_INT_MASK, 32'h0);
            wr(OFS_INT_STAT, 32'hF);
            field.pulse(0, 1, 2);
            wt(10);
            rdc(OFS_INT_STAT, 32'h4 << k);
            `CHK(irq, 1'b0)
            wr(OFS_INT_MASK, 32'hF);
            wt(1);
            `CHK(irq, 1'b1)
            wr(OFS_INT_STAT, 32'hF);
            wt(1);
            `CHK(irq, 1'b0)
        end
        $display("end events");
        summarize();
    end
    initial
    begin
        repeat (60000) @(posedge pclk);
        failures++;
        summarize();
    end
endmodule : tb_fioh_top
`default_nettype wire
